// file: dv/bml_board.sv
// Board model: reset source and the four request sources on the shared pins.
// Assumes the bench moves its controls at clk falling edges.
`timescale 1ns/1ps
module bml_board (
  // Bench controls
  input wire logic rst_req,
  input wire logic [3:0] boot_code,
  input wire logic [3:0] req_n,
  // Pins
  output logic nrst,
  output logic [3:0] pins
);
  // Reset is low from power-up until the bench lets go
  assign nrst = !rst_req;
  assign pins = nrst ? req_n : boot_code;
endmodule : bml_board

// file: dv/bml_props.sv
// Checker for the bml_top ports.
// Assumes the boot code stands on the pins at the first edge after reset release.
`timescale 1ns/1ps
module bml_props #(
  parameter int unsigned NUM_LINES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Shared pins
  input wire logic boot_select_bit_a,
  input wire logic boot_select_bit_b,
  input wire logic boot_select_bit_c,
  input wire logic boot_select_bit_d,
  // Controls
  input wire logic [NUM_LINES-1:0] edge_mode,
  input wire logic [NUM_LINES-1:0] req_enable,
  // Results
  input wire logic [3:0] op_mode,
  input wire logic mode_valid,
  input wire logic [NUM_LINES-1:0] irq_pending,
  input wire logic wake,
  input wire logic in_wait,
  input wire logic in_stop,
  input wire logic [1:0] phase
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_reset_clear: assert property (disable iff (1'b0) !nrst |-> !mode_valid && !irq_pending && !phase)
    else $error("reset state");
  chk_mode_latch: assert property ($rose(mode_valid) |->
    op_mode == $past({boot_select_bit_d, boot_select_bit_c, boot_select_bit_b, boot_select_bit_a}, 3))
    else $error("mode latch");
  chk_phase_step: assert property ($past(nrst) |-> phase == 2'($past(phase) + 2'h1)) else $error("phase step");
  chk_quiet_early: assert property (!mode_valid |-> !irq_pending) else $error("early request");
  chk_mask_blocks: assert property ((irq_pending & ~$past(req_enable)) == '0) else $error("mask");
  chk_level_req: assert property ((mode_valid && !edge_mode[0] && req_enable[0] && !boot_select_bit_a) [*3]
    |=> irq_pending[0]) else $error("level request");
  chk_stop_wake: assert property (in_stop && $fell(boot_select_bit_a) ##1 !boot_select_bit_a [*2]
    |=> wake && !in_stop) else $error("stop wake");
  chk_wait_wake: assert property (in_wait && $fell(boot_select_bit_b) ##1 !boot_select_bit_b [*2]
    |=> wake && !in_wait) else $error("wait wake");
  chk_stop_holds: assert property ((in_stop && boot_select_bit_a) [*3] |=> in_stop) else $error("stop");
  cover property ($rose(mode_valid));
  cover property ($fell(in_stop));
  cover property ($fell(in_wait));
endmodule : bml_props
bind bml_top bml_props #(
  .NUM_LINES(NUM_LINES)
) u_props (
  .clk(clk),
  .nrst(nrst),
  .boot_select_bit_a(boot_select_bit_a),
  .boot_select_bit_b(boot_select_bit_b),
  .boot_select_bit_c(boot_select_bit_c),
  .boot_select_bit_d(boot_select_bit_d),
  .edge_mode(edge_mode),
  .req_enable(req_enable),
  .op_mode(op_mode),
  .mode_valid(mode_valid),
  .irq_pending(irq_pending),
  .wake(wake),
  .in_wait(in_wait),
  .in_stop(in_stop),
  .phase(phase)
);

// file: dv/bml_top_tb.sv
// Testbench for bml_top with the board model driving reset and pins.
// Assumes inputs move at falling edges only.
`timescale 1ns/1ps
module bml_top_tb;
  logic clk = 0, rst_req = 1, enter_wait = 0, enter_stop = 0, nrst, mode_valid, irq_any, wake, in_wait, in_stop;
  logic [3:0] code = 4'h0, req_n = 4'hf, edge_mode = 4'h0, req_enable = 4'hf, edge_clear = 4'h0;
  logic [3:0] pins, op_mode, irq_pending;
  logic [1:0] phase;
  int fail_count = 0, samples_checked = 0;
  initial forever #12.5 clk = ~clk;
  bml_board u_board (.rst_req, .boot_code(code), .req_n, .nrst, .pins);
  bml_top u_dut (
    .clk(clk),
    .nrst(nrst),
    .boot_select_bit_a(pins[0]),
    .boot_select_bit_b(pins[1]),
    .boot_select_bit_c(pins[2]),
    .boot_select_bit_d(pins[3]),
    .edge_mode(edge_mode),
    .req_enable(req_enable),
    .edge_clear(edge_clear),
    .enter_wait(enter_wait),
    .enter_stop(enter_stop),
    .op_mode(op_mode),
    .mode_valid(mode_valid),
    .irq_pending(irq_pending),
    .irq_any(irq_any),
    .wake(wake),
    .in_wait(in_wait),
    .in_stop(in_stop),
    .phase(phase)
  );
  task automatic chk(string n, logic [3:0] e, logic [3:0] s);
    samples_checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic boot(logic [3:0] m);
    rst_req = 1;
    code = m;
    req_n = m;
    cyc(10);
    chk("phase", 4'h0, {2'h0, phase});
    chk("valid_in_reset", 4'h0, {3'h0, mode_valid});
    rst_req = 0;
    cyc(3);
    chk("op_mode", m, op_mode);
    chk("mode_valid", 4'h1, {3'h0, mode_valid});
    chk("early", 4'h0, irq_pending);
    req_n = 4'hf;
    cyc(4);
  endtask : boot
  task automatic requests;
    req_n = 4'h5;
    cyc(3);
    chk("level", 4'ha, irq_pending);
    chk("any", 4'h1, {3'h0, irq_any});
    req_enable = 4'h2;
    cyc(1);
    chk("mask", 4'h2, irq_pending);
    req_enable = 4'hf;
    req_n = 4'hf;
    edge_mode = 4'hf;
    // Flags set by the level-mode falls must not leak into edge mode
    edge_clear = 4'hf;
    cyc(1);
    edge_clear = 4'h0;
    cyc(3);
    req_n = 4'he;
    cyc(2);
    req_n = 4'hf;
    cyc(4);
    chk("sticky", 4'h1, irq_pending);
    edge_clear = 4'h1;
    cyc(1);
    edge_clear = 4'h0;
    edge_mode = 4'h0;
    chk("cleared", 4'h0, irq_pending);
    chk("any_cleared", 4'h0, {3'h0, irq_any});
    $display("requests done");
  endtask : requests
  task automatic standby;
    enter_stop = 1;
    cyc(1);
    enter_stop = 0;
    req_n = 4'h1;
    cyc(5);
    chk("stop_held", 4'h1, {3'h0, in_stop});
    req_n = 4'hf;
    cyc(3);
    req_n = 4'he;
    cyc(3);
    chk("stop_wake", 4'h3, {2'h0, wake, !in_stop});
    for (int i = 0; i < 4; i++)
    begin
      req_n = 4'hf;
      cyc(3);
      enter_wait = 1;
      cyc(1);
      enter_wait = 0;
      req_n = ~(4'h1 << i);
      cyc(3);
      chk("wait_wake", 4'h3, {2'h0, wake, !in_wait});
    end
    $display("standby done");
  endtask : standby
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    for (int m = 0; m < 16; m++)
      boot(4'(m));
    $display("boot done");
    requests();
    standby();
    tally_and_finish();
  end
  // Normal run is under 500 cycles
  initial
  begin
    cyc(2000);
    fail_count++;
    tally_and_finish();
  end
endmodule : bml_top_tb

// file: src/bml_pkg.sv
// Package for the boot-mode latch and external request block.
// Assumes a single 40 MHz clock domain and no software-visible registers.
package bml_pkg;
  localparam int unsigned NUM_LINES = 4;
  localparam int unsigned MODE_W = 4;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [3:0] LINES_IDLE = 4'hf;
  localparam int unsigned LINE_A = 0;
  localparam int unsigned PHASE_W = 2;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  // Power modes of the processor as seen by this block
  typedef enum logic [2:0]
  {
    BML_RUN = 3'h1,
    BML_WAIT = 3'h2,
    BML_STOP = 3'h4
  } bml_power_t;
  // Lifecycle of the shared pins
  typedef enum logic [2:0]
  {
    BML_HELD = 3'h1,
    BML_LATCH = 3'h2,
    BML_IRQ = 3'h4
  } bml_phase_t;
endpackage : bml_pkg

// file: src/bml_sync.sv
// Two-flop synchroniser for the four shared pins.
// Assumes pins are asynchronous to clk; resets to the idle (high) level.
`timescale 1ns/1ps
module bml_sync #(
  parameter int unsigned WIDTH = 4,
  parameter logic [WIDTH-1:0] IDLE = '1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pins in, synchronised out
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] sync
);
  typedef struct packed
  {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } bml_sync_state_t;

  bml_sync_state_t state;
  bml_sync_state_t next_state;

  always_comb
  begin
    next_state = state;
    next_state.stage1 = pin;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= {IDLE, IDLE};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign sync = state.stage2;
endmodule : bml_sync

// file: src/bml_top.sv
// Boot-mode latch and external interrupt request front end.
// Assumes nrst is the chip reset pin, already clean and asynchronous; pins are board-level inputs.
`timescale 1ns/1ps
// Function
// - On reset release, latch four mode pins as the operating mode code.
// - After reset release, the same four pins act as interrupt requests.
// - Each request is level or falling-edge triggered, and individually maskable.
// - Request A asserted in STOP or WAIT makes the processor leave standby.
// - Requests B, C, D asserted in WAIT leave WAIT; they do not end STOP.
// - While reset is asserted, all state and the phase generator are reset.
module bml_top #(
  parameter int unsigned NUM_LINES = bml_pkg::NUM_LINES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Shared mode and request pins, active low as requests
  input wire logic boot_select_bit_a,
  input wire logic boot_select_bit_b,
  input wire logic boot_select_bit_c,
  input wire logic boot_select_bit_d,
  // Processor-side controls
  input wire logic [NUM_LINES-1:0] edge_mode,
  input wire logic [NUM_LINES-1:0] req_enable,
  input wire logic [NUM_LINES-1:0] edge_clear,
  input wire logic enter_wait,
  input wire logic enter_stop,
  // Results
  output logic [3:0] op_mode,
  output logic mode_valid,
  output logic [NUM_LINES-1:0] irq_pending,
  output logic irq_any,
  output logic wake,
  output logic in_wait,
  output logic in_stop,
  output logic [1:0] phase
);
  // ext_request_a_n..d_n are the same pins once reset is over
  logic [NUM_LINES-1:0] pins_sync;

  typedef struct packed
  {
    bml_pkg::bml_phase_t life;
    logic settle;
    logic [3:0] mode;
    logic mode_valid;
    logic [NUM_LINES-1:0] prev;
    logic [NUM_LINES-1:0] edge_latched;
    logic [NUM_LINES-1:0] pending;
    logic any;
    bml_pkg::bml_power_t power;
    logic in_wait;
    logic in_stop;
    logic wake;
    logic [1:0] phase;
  } bml_state_t;

  bml_state_t state;
  bml_state_t next_state;

  // Wake qualification per line: A ends STOP or WAIT, others only WAIT
  function automatic logic line_wakes(input int unsigned idx, input bml_pkg::bml_power_t pw);
    line_wakes = (pw == bml_pkg::BML_WAIT) || (idx == bml_pkg::LINE_A && pw == bml_pkg::BML_STOP);
  endfunction : line_wakes

  bml_sync #(
    .WIDTH(NUM_LINES),
    .IDLE(bml_pkg::LINES_IDLE)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .pin({boot_select_bit_d, boot_select_bit_c, boot_select_bit_b, boot_select_bit_a}),
    .sync(pins_sync)
  );

  // Release timeline in rising edges after nrst goes high:
  // E0 first flop takes the pins, E1 second flop holds them,
  // E2 mode is latched and detection armed, E3 first request update.
  // The mode pins must therefore stay put until E0 has passed.
  always_comb
  begin
    logic [NUM_LINES-1:0] active;
    logic wake_hit;
    logic [NUM_LINES-1:0] masked;
    active = '0;
    wake_hit = 1'b0;
    masked = '0;
    next_state = state;
    next_state.wake = 1'b0;
    next_state.phase = 2'(state.phase + 2'h1);
    case (state.life)
      bml_pkg::BML_HELD:
      begin
        // Wait one extra edge: until then the second flop still shows its idle
        // reset level, which would be taken as the mode
        if (state.settle)
        begin
          next_state.life = bml_pkg::BML_LATCH;
        end
        else
        begin
          next_state.settle = 1'b1;
        end
      end
      bml_pkg::BML_LATCH:
      begin
        next_state.mode = pins_sync;
        next_state.mode_valid = 1'b1;
        next_state.prev = pins_sync;
        next_state.life = bml_pkg::BML_IRQ;
      end
      bml_pkg::BML_IRQ:
      begin
        for (int unsigned i = 0; i < NUM_LINES; i++)
        begin
          // Falling edge sets a sticky flag; set wins over a same-cycle clear
          // Edges are tracked in level mode too; clear the flag when switching to edge mode
          if (state.prev[i] && !pins_sync[i])
          begin
            next_state.edge_latched[i] = 1'b1;
          end
          else if (edge_clear[i])
          begin
            next_state.edge_latched[i] = 1'b0;
          end
          active[i] = edge_mode[i] ? next_state.edge_latched[i] : !pins_sync[i];
          if (active[i] && line_wakes(i, state.power))
          begin
            wake_hit = 1'b1;
          end
        end
        next_state.prev = pins_sync;
        masked = active & req_enable;
        next_state.pending = masked;
        next_state.any = |masked;
      end
      default:
      begin
        next_state.life = bml_pkg::BML_HELD;
      end
    endcase
    // Wake uses raw activity so a masked line still ends standby
    case (state.power)
      bml_pkg::BML_RUN:
      begin
        if (enter_stop)
        begin
          next_state.power = bml_pkg::BML_STOP;
        end
        else if (enter_wait)
        begin
          next_state.power = bml_pkg::BML_WAIT;
        end
      end
      bml_pkg::BML_WAIT, bml_pkg::BML_STOP:
      begin
        if (wake_hit)
        begin
          next_state.power = bml_pkg::BML_RUN;
          next_state.wake = 1'b1;
        end
      end
      default:
      begin
        next_state.power = bml_pkg::BML_RUN;
      end
    endcase
    // Decoded here so the standby outputs leave straight from flops
    next_state.in_wait = (next_state.power == bml_pkg::BML_WAIT);
    next_state.in_stop = (next_state.power == bml_pkg::BML_STOP);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state.life <= bml_pkg::BML_HELD;
      state.settle <= 1'b0;
      state.mode <= bml_pkg::MODE_RESET;
      state.mode_valid <= 1'b0;
      state.prev <= bml_pkg::LINES_IDLE;
      state.edge_latched <= '0;
      state.pending <= '0;
      state.any <= 1'b0;
      state.power <= bml_pkg::BML_RUN;
      state.in_wait <= 1'b0;
      state.in_stop <= 1'b0;
      state.wake <= 1'b0;
      state.phase <= bml_pkg::PHASE_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign op_mode = state.mode;
  assign mode_valid = state.mode_valid;
  assign irq_pending = state.pending;
  assign irq_any = state.any;
  assign wake = state.wake;
  assign in_wait = state.in_wait;
  assign in_stop = state.in_stop;
  assign phase = state.phase;
endmodule : bml_top
